// File: input_port_pkg.sv
//------------------------------------------------------------
// Behaviour
//------------------------------------------------------------
// Behaviour
// - pin level register reads live pins
// - four-bit read/write enables, reset zero
// - enabled pin going active sets flag
// - rising edge or re-enable while high
// - filter delays flag at most 0.5 ms
// - flag in bit 0, upper bits zero
// - reading flag register clears flag
// - flag zero after reset
// - request raised while flag set, whatever the enables
// - per-pin pull-down build option
`default_nettype none

package input_port_pkg;

   localparam int          PIN_COUNT      = 4;
   localparam int          ADDR_W         = 8;
   localparam int          DATA_W         = 4;

   localparam logic [7:0]  ADDR_PIN_LEVELS = 8'he0;
   localparam logic [7:0]  ADDR_IRQ_ENABLE = 8'he8;
   localparam logic [7:0]  ADDR_IRQ_FLAG   = 8'hed;

   localparam logic [3:0]  ENABLE_RESET   = 4'h0;
   localparam logic        FLAG_RESET     = 1'b0;
   localparam int          FLAG_BIT       = 0;

   // filter and pull-down build options
   localparam logic [3:0]  PULL_DOWN_MASK = 4'hf;
   localparam logic        FILTER_USED    = 1'b1;

   localparam int          CLK_HZ         = 100_000_000;
   localparam int          FILTER_MAX_US  = 500;
   // longest delay rounds down
   localparam int          FILTER_CYCLES  =
      (FILTER_MAX_US * (CLK_HZ / 1_000_000)) - 2;

   typedef struct packed
   {
      logic              rd;
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } cpu_req_s;

endpackage : input_port_pkg

`default_nettype wire

// File: pin_sync.sv
`default_nettype none

module pin_sync
   import input_port_pkg::*;
(
   input  wire logic                 sys_clk_in,
   input  wire logic                 rst_in,
   input  wire logic [PIN_COUNT-1:0] pin_in,
   output logic      [PIN_COUNT-1:0] level_out
);

   logic [PIN_COUNT-1:0] stage1;
   logic [PIN_COUNT-1:0] stage2;

   //------------------------------------------------------------
   // two-flop synchroniser
   //------------------------------------------------------------
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         stage1 <= '0;
         stage2 <= '0;
      end
      else
      begin
         stage1 <= pin_in;
         stage2 <= stage1;
      end
   end

   assign level_out = stage2;

endmodule // pin_sync

`default_nettype wire

// File: noise_filter.sv
`default_nettype none

module noise_filter
   import input_port_pkg::*;
(
   input  wire logic                 sys_clk_in,
   input  wire logic                 rst_in,
   input  wire logic [PIN_COUNT-1:0] level_in,
   output logic      [PIN_COUNT-1:0] level_out
);

   localparam int CNT_W = $clog2(FILTER_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FILTER_CYCLES);

   logic [CNT_W-1:0] count      [PIN_COUNT];
   logic [CNT_W-1:0] next_count [PIN_COUNT];
   logic [PIN_COUNT-1:0] held;
   logic [PIN_COUNT-1:0] next_held;

   //------------------------------------------------------------
   // per-pin stability filter
   //------------------------------------------------------------
   // a level must stay put for the full window; this bounds
   // the added flag latency while rejecting short glitches
   genvar g;
   generate
      for (g = 0; g < PIN_COUNT; g++)
      begin : g_pin
         always_comb
         begin
            next_count[g] = '0;
            next_held[g]  = held[g];
            if (!FILTER_USED)
               next_held[g] = level_in[g];
            else if (level_in[g] != held[g])
            begin
               if (count[g] == CNT_LAST)
                  next_held[g] = level_in[g];
               else
                  next_count[g] = count[g] + 1'b1;
            end
         end

         always_ff @(posedge sys_clk_in)
         begin
            if (rst_in)
            begin
               count[g] <= '0;
               held[g]  <= 1'b0;
            end
            else
            begin
               count[g] <= next_count[g];
               held[g]  <= next_held[g];
            end
         end
      end
   endgenerate

   assign level_out = held;

   a_filter_bound : assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      (level_in[0] != held[0]) && (count[0] == CNT_LAST)
      |=> held[0] == $past(level_in[0]))
      else $error("filter held level too long");

endmodule // noise_filter

`default_nettype wire

// File: input_port_with_interrupt.sv
`default_nettype none

module input_port_with_interrupt
   import input_port_pkg::*;
(
   input  wire logic                 sys_clk_in,
   input  wire logic                 rst_in,
   input  wire logic [PIN_COUNT-1:0] input_pins_in,
   input  wire cpu_req_s             cpu_req_in,
   output logic      [DATA_W-1:0]    rdata_out,
   output logic      [PIN_COUNT-1:0] pull_down_en_out,
   output logic                      irq_out
);

   localparam int WAIT_W = $clog2(FILTER_CYCLES + 3);

   logic [PIN_COUNT-1:0] pin_level;
   logic [PIN_COUNT-1:0] filt_level;
   logic [PIN_COUNT-1:0] prev_active;
   logic [PIN_COUNT-1:0] next_prev_active;
   logic [PIN_COUNT-1:0] enables;
   logic [PIN_COUNT-1:0] next_enables;
   logic                 shared_input_irq_flag;
   logic                 next_flag;
   logic [DATA_W-1:0]    next_rdata;
   logic [PIN_COUNT-1:0] active;
   logic                 set_event;
   logic                 flag_read;
   logic [WAIT_W-1:0]    wait_count;
   logic [WAIT_W-1:0]    next_wait_count;

   //------------------------------------------------------------
   // pin conditioning
   //------------------------------------------------------------
   pin_sync u_sync
   (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .pin_in     (input_pins_in),
      .level_out  (pin_level)
   );

   noise_filter u_filter
   (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .level_in   (pin_level),
      .level_out  (filt_level)
   );

   // pads apply the pull-down only where the build option asks
   assign pull_down_en_out = PULL_DOWN_MASK;

   //------------------------------------------------------------
   // interrupt condition
   //------------------------------------------------------------
   // the condition is the gated level, so unmasking an already
   // high pin also looks like a rising edge
   assign active    = filt_level & enables;
   assign set_event = |(active & ~prev_active);
   assign flag_read = cpu_req_in.rd
                      && (cpu_req_in.addr == ADDR_IRQ_FLAG);

   always_comb
   begin
      next_prev_active = active;
      next_enables     = enables;
      next_flag        = shared_input_irq_flag;
      next_rdata       = '0;
      if (cpu_req_in.wr && (cpu_req_in.addr == ADDR_IRQ_ENABLE))
         next_enables = cpu_req_in.wdata[PIN_COUNT-1:0];
      // set wins over the read-clear so no edge is lost
      if (flag_read)
         next_flag = 1'b0;
      if (set_event)
         next_flag = 1'b1;
      if (cpu_req_in.rd)
      begin
         case (cpu_req_in.addr)
            ADDR_PIN_LEVELS: next_rdata = pin_level;
            ADDR_IRQ_ENABLE: next_rdata = enables;
            ADDR_IRQ_FLAG:
               next_rdata[FLAG_BIT] = shared_input_irq_flag;
            default:         next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         prev_active           <= '0;
         enables               <= ENABLE_RESET;
         shared_input_irq_flag <= FLAG_RESET;
         rdata_out             <= '0;
      end
      else
      begin
         prev_active           <= next_prev_active;
         enables               <= next_enables;
         shared_input_irq_flag <= next_flag;
         rdata_out             <= next_rdata;
      end
   end

   // request follows the flag; a read may race the set
   assign irq_out = shared_input_irq_flag;

   //------------------------------------------------------------
   // filter latency watch
   //------------------------------------------------------------
   // counts how long pin 0 has been high in front of the filter
   // but not behind it; only the latency check reads it
   always_comb
   begin
      next_wait_count = '0;
      if (pin_level[0] && !filt_level[0])
      begin
         if (wait_count != '1)
            next_wait_count = wait_count + 1'b1;
         else
            next_wait_count = wait_count;
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
         wait_count <= '0;
      else
         wait_count <= next_wait_count;
   end

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   a_pin_read : assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      cpu_req_in.rd && cpu_req_in.addr == ADDR_PIN_LEVELS
      |=> rdata_out == $past(pin_level))
      else $error("pin level read wrong");

   a_enable_write : assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      cpu_req_in.wr && cpu_req_in.addr == ADDR_IRQ_ENABLE
      |=> enables == $past(cpu_req_in.wdata))
      else $error("enable write lost");

   a_masked_quiet : assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      !shared_input_irq_flag && (active == '0) && !set_event
      |=> !shared_input_irq_flag)
      else $error("flag set with no enabled pin");

   a_edge_sets : assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      (filt_level[0] && enables[0] && !prev_active[0])
      |=> shared_input_irq_flag)
      else $error("rising edge missed");

   a_flag_bits : assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      cpu_req_in.rd && cpu_req_in.addr == ADDR_IRQ_FLAG
      |=> rdata_out[DATA_W-1:1] == '0
          && rdata_out[0] == $past(shared_input_irq_flag))
      else $error("flag register read wrong");

   a_read_clears : assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      flag_read && !set_event |=> !shared_input_irq_flag)
      else $error("read did not clear flag");

   a_reset_flag : assert property (
      @(posedge sys_clk_in)
      rst_in |=> !shared_input_irq_flag && enables == '0)
      else $error("reset state wrong");

   a_irq_follows : assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      set_event |=> irq_out ##0 $rose(irq_out) or $past(irq_out))
      else $error("request not raised");

   //------------------------------------------------------------
   // register and flag invariants
   //------------------------------------------------------------
   // a write to the pin register must not leak into the enables
   a_pins_write_ignored : assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      cpu_req_in.wr && cpu_req_in.addr == ADDR_PIN_LEVELS
      |=> enables == $past(enables))
      else $error("pin register write had effect");

   // software cannot set or clear the flag by writing
   a_flag_write_ignored : assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      cpu_req_in.wr && cpu_req_in.addr == ADDR_IRQ_FLAG
      && !flag_read && !set_event
      |=> shared_input_irq_flag == $past(shared_input_irq_flag))
      else $error("flag register write had effect");

   // enables move only on a write to their own address
   a_enable_hold : assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      !(cpu_req_in.wr && cpu_req_in.addr == ADDR_IRQ_ENABLE)
      |=> enables == $past(enables))
      else $error("enables changed without write");

   // once set the flag waits for the processor to read it
   a_flag_sticky : assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      shared_input_irq_flag && !flag_read
      |=> shared_input_irq_flag)
      else $error("flag dropped without read");

   // masked pins can never produce a set event
   a_masked_no_set : assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      (active == '0) |-> !set_event)
      else $error("set event with all pins masked");

   // the flag stays clear unless an event arrives
   a_flag_only_event : assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      !shared_input_irq_flag && !set_event
      |=> !shared_input_irq_flag)
      else $error("flag set without event");

   // an edge in the read cycle must survive the clear
   a_set_wins : assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      flag_read && set_event |=> shared_input_irq_flag)
      else $error("edge lost to read clear");

   // unmasking a pin that is already high counts as an edge
   a_reenable_high : assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      filt_level[1] && !enables[1] && cpu_req_in.wr
      && cpu_req_in.addr == ADDR_IRQ_ENABLE && cpu_req_in.wdata[1]
      |=> ##1 shared_input_irq_flag)
      else $error("re-enable while high missed");

   // the top pin reaches the shared flag as well
   a_edge_top_pin : assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      filt_level[PIN_COUNT-1] && enables[PIN_COUNT-1]
      && !prev_active[PIN_COUNT-1]
      |=> shared_input_irq_flag)
      else $error("top pin edge missed");

   // edge detection compares against the previous gated level
   a_prev_tracks : assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      1'b1 |=> prev_active == $past(active))
      else $error("edge history wrong");

   // read data stands for one cycle and is zero otherwise
   a_rdata_idle : assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      !cpu_req_in.rd |=> rdata_out == '0)
      else $error("read data without read");

   // addresses outside the block read as zero
   a_unmapped_zero : assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      cpu_req_in.rd && cpu_req_in.addr != ADDR_PIN_LEVELS
      && cpu_req_in.addr != ADDR_IRQ_ENABLE
      && cpu_req_in.addr != ADDR_IRQ_FLAG
      |=> rdata_out == '0)
      else $error("unmapped read not zero");

   // enables read back as written
   a_enable_read : assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      cpu_req_in.rd && cpu_req_in.addr == ADDR_IRQ_ENABLE
      |=> rdata_out == $past(enables))
      else $error("enable read wrong");

   // the pads see the build option unchanged
   a_pull_mask : assert property (
      @(posedge sys_clk_in)
      pull_down_en_out == PULL_DOWN_MASK)
      else $error("pull-down mask wrong");

   // the request line is the flag itself
   a_irq_is_flag : assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      irq_out == shared_input_irq_flag)
      else $error("request differs from flag");

   // reset leaves nothing on the read bus or the request
   a_reset_outputs : assert property (
      @(posedge sys_clk_in)
      rst_in |=> rdata_out == '0 && !irq_out)
      else $error("outputs not quiet after reset");

   // a steady high pin must pass the filter within its window
   a_filter_latency : assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      wait_count <= FILTER_CYCLES + 1)
      else $error("filter delay over bound");

endmodule // input_port_with_interrupt

`default_nettype wire

// File: pin_source.sv
`default_nettype none

module pin_source
   import input_port_pkg::*;
(
   input  wire logic [PIN_COUNT-1:0] drive_in,
   input  wire logic [PIN_COUNT-1:0] drive_en_in,
   input  wire logic [PIN_COUNT-1:0] pull_down_in,
   output logic      [PIN_COUNT-1:0] pins_out
);
   timeunit 1ns;
   timeprecision 1ps;

   //------------------------------------------------------------
   // released pins fall to the pull-down, else show no stale level
   //------------------------------------------------------------
   always_comb
   begin
      for (int i = 0; i < PIN_COUNT; i++)
      begin
         if (drive_en_in[i])
            pins_out[i] = drive_in[i];
         else
            pins_out[i] = pull_down_in[i] ? 1'b0 : ~drive_in[i];
      end
   end
endmodule // pin_source

`default_nettype wire

// File: testbench.sv
`default_nettype none

module testbench
   import input_port_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic           sys_clk_in = 1'b0;
   logic           rst_in     = 1'b1;
   cpu_req_s       req        = '0;
   logic [3:0]     drive      = 4'h0;
   logic [3:0]     drive_en   = 4'h0;
   logic [3:0]     pins;
   logic [3:0]     pull_down;
   logic [3:0]     rdata;
   logic           irq;
   logic [3:0]     d;
   int             errors     = 0;
   int             tests_run  = 0;
   int             seed       = 39;
   int             k;

   pin_source far_side (.drive_in(drive), .drive_en_in(drive_en),
      .pull_down_in(pull_down), .pins_out(pins));

   input_port_with_interrupt dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .input_pins_in(pins), .cpu_req_in(req), .rdata_out(rdata),
      .pull_down_en_out(pull_down), .irq_out(irq));

   initial
   begin
      forever #5 sys_clk_in = ~sys_clk_in;
   end

   //------------------------------------------------------------
   // bus cycles and comparison
   //------------------------------------------------------------
   task automatic chk(input string n, input logic [3:0] e,
                      input logic [3:0] s);
      tests_run++;
      if (s !== e)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic rd(input logic [7:0] a, output logic [3:0] v);
      @(posedge sys_clk_in) req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 4'h0};
      @(posedge sys_clk_in) req <= '0;
      #1 v = rdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [3:0] v);
      @(posedge sys_clk_in) req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
      @(posedge sys_clk_in) req <= '0;
   endtask

   task automatic give_verdict;
      if (errors == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // one filtered rising edge costs about 50k cycles of the run
   initial
   begin
      repeat (60000) @(posedge sys_clk_in);
      errors++;
      give_verdict();
   end

   //------------------------------------------------------------
   // main sequence
   //------------------------------------------------------------
   initial
   begin
      drive_en = 4'hf;
      repeat (20) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      #1 chk("irq after reset", 4'h0, {3'h0, irq});
      chk("pull-down mask", PULL_DOWN_MASK, pull_down);
      rd(ADDR_IRQ_ENABLE, d);
      chk("enables after reset", ENABLE_RESET, d);
      rd(ADDR_IRQ_FLAG, d);
      chk("flag after reset", 4'h0, d);
      for (int i = 0; i < 8; i++)
      begin
         @(posedge sys_clk_in) drive <= 4'($random(seed));
         repeat (4) @(posedge sys_clk_in);
         wr(ADDR_PIN_LEVELS, ~drive);
         rd(ADDR_PIN_LEVELS, d);
         chk("pin levels", drive, d);
         wr(ADDR_IRQ_ENABLE, ~drive);
         rd(ADDR_IRQ_ENABLE, d);
         chk("enables", ~drive, d);
         wr(ADDR_IRQ_ENABLE, 4'h0);
      end
      rd(8'h11, d);
      chk("unmapped read", 4'h0, d);
      rd(ADDR_IRQ_FLAG, d);
      // pin 0 is enabled while low, the others rise masked
      wr(ADDR_IRQ_ENABLE, 4'h1);
      @(posedge sys_clk_in) drive <= 4'hf;
      k = 0;
      while (irq !== 1'b1 && k < 50010)
      begin
         @(posedge sys_clk_in);
         #1 k++;
      end
      chk("rising edge irq", 4'h1, {3'h0, irq});
      chk("filter held off", 4'h1, {3'h0, k >= 40000});
      rd(ADDR_IRQ_FLAG, d);
      chk("rising edge flag", 4'h1, d);
      #1 chk("irq after edge read", 4'h0, {3'h0, irq});
      repeat (5) @(posedge sys_clk_in);
      #1 chk("masked pins irq", 4'h0, {3'h0, irq});
      wr(ADDR_IRQ_FLAG, 4'hf);
      rd(ADDR_IRQ_FLAG, d);
      chk("masked pins flag", 4'h0, d);
      wr(ADDR_IRQ_ENABLE, 4'hf);
      repeat (3) @(posedge sys_clk_in);
      #1 chk("re-enable while high", 4'h1, {3'h0, irq});
      rd(ADDR_IRQ_FLAG, d);
      chk("flag read", 4'h1, d);
      #1 chk("irq after read", 4'h0, {3'h0, irq});
      rd(ADDR_IRQ_FLAG, d);
      chk("flag cleared", 4'h0, d);
      give_verdict();
   end
endmodule // testbench

`default_nettype wire
